/* File: scs_defs.svh */
// Overview of operation
// - Filter bit zero selects sinc decimator
// - Sinc results settle after three conversion cycles
// - Sinc mode withholds first two outputs
// - Start on pin rise or seventh SCLK fall
// - Programmable delay before first conversion, default 14
// - Modulator period equals sixteen converter clocks
// - Later continuous conversions carry no delay
// - First conversion: delay, sampling, then overhead
// - Continuous results one data period apart
// - Overhead interval precedes the first readable result after each start
// - Suppressed sinc outputs skip overhead interval
// - Conversion durations follow per-rate counts
// - Same sequence structure for both filters
// - Low-latency filter: every output settled
// - Sinc response scales with data rate
// - All timing scales with converter clock
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

`define SCS_CNT_W        17
`define SCS_MOD_DIV_LAST 4'hF
`define SCS_SUP_OUTPUTS  2'h2
`define SCS_START_CMD7   7'h04
`define SCS_SPI_BIT7     3'h6
`define SCS_FILTER_SINC  1'h0

// Data period per rate code, in modulator periods
`define SCS_PER_0        17'h1_9000
`define SCS_PER_1        17'h0_C800
`define SCS_PER_2        17'h0_6400
`define SCS_PER_3        17'h0_3C00
`define SCS_PER_4        17'h0_3200
`define SCS_PER_5        17'h0_1400
`define SCS_PER_6        17'h0_10A8
`define SCS_PER_7        17'h0_0A00
`define SCS_PER_8        17'h0_0500
`define SCS_PER_9        17'h0_0280
`define SCS_PER_10       17'h0_0140
`define SCS_PER_11       17'h0_0100
`define SCS_PER_12       17'h0_0080
`define SCS_PER_13       17'h0_0040
// Result overhead, slow and fast rate groups
`define SCS_OH_SLOW      17'h0_0041
`define SCS_OH_FAST      17'h0_0028
`define SCS_FAST_FIRST   4'hB

// Programmable delay per delay code, in modulator periods
`define SCS_DLY_0        17'h0_000E
`define SCS_DLY_1        17'h0_001C
`define SCS_DLY_2        17'h0_0038
`define SCS_DLY_3        17'h0_0070
`define SCS_DLY_4        17'h0_00E0
`define SCS_DLY_5        17'h0_01C0
`define SCS_DLY_6        17'h0_0380
`define SCS_DLY_7        17'h0_0001

`endif

/* File: scs_host_model.sv */
`timescale 1ns/1ps

module scs_host_model
(
    input  wire logic clk_i,
    output logic      conv_clk_o,
    output logic      start_pin_o,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o
);
    logic [1:0] div;

    initial
    begin
        div         = 2'h0;
        conv_clk_o  = 1'b0;
        start_pin_o = 1'b0;
        sclk_o      = 1'b0;
        cs_n_o      = 1'b1;
        mosi_o      = 1'b0;
    end

    // Free-running converter clock, six system clocks per period
    always @(posedge clk_i)
    begin
        if (div == 2'h2)
        begin
            div        <= 2'h0;
            conv_clk_o <= ~conv_clk_o;
        end
        else
            div <= div + 2'h1;
    end

    task pulse_start();
        @(posedge clk_i);
        start_pin_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        start_pin_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask : pulse_start

    // One byte MSB first; the device shifts on each falling SCLK edge
    task send_byte(input logic [7:0] b);
        int i;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (i = 7; i >= 0; i--)
        begin
            mosi_o <= b[i];
            sclk_o <= 1'b1;
            repeat (16) @(posedge clk_i);
            sclk_o <= 1'b0;
            repeat (16) @(posedge clk_i);
        end
        cs_n_o <= 1'b1;
        // Released line shows no stale data
        mosi_o <= ~mosi_o;
        repeat (4) @(posedge clk_i);
    endtask : send_byte
endmodule : scs_host_model

/* File: scs_pkg.sv */
package scs_pkg;

    typedef enum logic [2:0]
    {
        ST_IDLE     = 3'b000,
        ST_DELAY    = 3'b001,
        ST_SAMPLE   = 3'b010,
        ST_OVERHEAD = 3'b011,
        ST_NEXT     = 3'b100
    } scs_state_type;

endpackage : scs_pkg

/* File: scs_rate_rom.sv */
`timescale 1ns/1ps
`include "scs_defs.svh"

module scs_rate_rom
    import scs_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic [3:0]             rate_sel_i,
    input  wire logic [2:0]             delay_sel_i,
    output logic      [`SCS_CNT_W-1:0]  period_o,
    output logic      [`SCS_CNT_W-1:0]  overhead_o,
    output logic      [`SCS_CNT_W-1:0]  delay_o
);

    logic [`SCS_CNT_W-1:0] period;
    logic [`SCS_CNT_W-1:0] overhead;
    logic [`SCS_CNT_W-1:0] delay;
    logic [`SCS_CNT_W-1:0] next_period;
    logic [`SCS_CNT_W-1:0] next_overhead;
    logic [`SCS_CNT_W-1:0] next_delay;

    // Data period per rate; filter nulls follow the same rate
    always_comb
    begin
        case (rate_sel_i)
            4'h0:    next_period = `SCS_PER_0;
            4'h1:    next_period = `SCS_PER_1;
            4'h2:    next_period = `SCS_PER_2;
            4'h3:    next_period = `SCS_PER_3;
            4'h4:    next_period = `SCS_PER_4;
            4'h5:    next_period = `SCS_PER_5;
            4'h6:    next_period = `SCS_PER_6;
            4'h7:    next_period = `SCS_PER_7;
            4'h8:    next_period = `SCS_PER_8;
            4'h9:    next_period = `SCS_PER_9;
            4'hA:    next_period = `SCS_PER_10;
            4'hB:    next_period = `SCS_PER_11;
            4'hC:    next_period = `SCS_PER_12;
            default: next_period = `SCS_PER_13;
        endcase
        next_overhead = (rate_sel_i >= `SCS_FAST_FIRST) ? `SCS_OH_FAST : `SCS_OH_SLOW;
        case (delay_sel_i)
            3'h0:    next_delay = `SCS_DLY_0;
            3'h1:    next_delay = `SCS_DLY_1;
            3'h2:    next_delay = `SCS_DLY_2;
            3'h3:    next_delay = `SCS_DLY_3;
            3'h4:    next_delay = `SCS_DLY_4;
            3'h5:    next_delay = `SCS_DLY_5;
            3'h6:    next_delay = `SCS_DLY_6;
            default: next_delay = `SCS_DLY_7;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            period   <= `SCS_PER_13;
            overhead <= `SCS_OH_FAST;
            delay    <= `SCS_DLY_0;
        end
        else
        begin
            period   <= next_period;
            overhead <= next_overhead;
            delay    <= next_delay;
        end
    end

    assign period_o   = period;
    assign overhead_o = overhead;
    assign delay_o    = delay;

endmodule : scs_rate_rom

/* File: scs_sequencer.sv */
`timescale 1ns/1ps
`include "scs_defs.svh"

module scs_sequencer
    import scs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        conv_clk_i,
    input  wire logic        start_pin_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    input  wire logic        filter_sel_i,
    input  wire logic        continuous_i,
    input  wire logic [2:0]  delay_sel_i,
    input  wire logic [3:0]  rate_sel_i,
    output logic             busy_o,
    output logic             result_ready_o,
    output logic [15:0]      result_count_o,
    output logic [2:0]       phase_o
);

    logic                   conv_rise;
    logic                   start_rise;
    logic                   sclk_fall;
    logic                   cs_n_lvl;
    logic                   mosi_lvl;
    logic [`SCS_CNT_W-1:0]  period;
    logic [`SCS_CNT_W-1:0]  overhead;
    logic [`SCS_CNT_W-1:0]  delay;

    scs_state_type          state;
    scs_state_type          next_state;
    logic [3:0]             div;
    logic [3:0]             next_div;
    logic [`SCS_CNT_W-1:0]  cnt;
    logic [`SCS_CNT_W-1:0]  next_cnt;
    logic [1:0]             sup;
    logic [1:0]             next_sup;
    logic [6:0]             shift;
    logic [6:0]             next_shift;
    logic [2:0]             bit_cnt;
    logic [2:0]             next_bit_cnt;
    logic                   ready;
    logic                   next_ready;
    logic [15:0]            count;
    logic [15:0]            next_count;

    logic                   mod_tick;
    logic                   period_end;
    logic                   spi_start;
    logic                   start_evt;
    logic                   filt_sinc;
    logic [6:0]             cmd_bits;

    scs_sync3 #(.INIT(1'b0)) u_conv_clk
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (conv_clk_i),
        .level_o (),
        .rise_o  (conv_rise),
        .fall_o  ()
    );

    scs_sync3 #(.INIT(1'b0)) u_start_pin
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (start_pin_i),
        .level_o (),
        .rise_o  (start_rise),
        .fall_o  ()
    );

    scs_sync3 #(.INIT(1'b0)) u_sclk
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (sclk_i),
        .level_o (),
        .rise_o  (),
        .fall_o  (sclk_fall)
    );

    scs_sync3 #(.INIT(1'b1)) u_cs_n
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (cs_n_i),
        .level_o (cs_n_lvl),
        .rise_o  (),
        .fall_o  ()
    );

    scs_sync3 #(.INIT(1'b0)) u_mosi
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (mosi_i),
        .level_o (mosi_lvl),
        .rise_o  (),
        .fall_o  ()
    );

    scs_rate_rom u_rate_rom
    (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .rate_sel_i  (rate_sel_i),
        .delay_sel_i (delay_sel_i),
        .period_o    (period),
        .overhead_o  (overhead),
        .delay_o     (delay)
    );

    assign filt_sinc  = (filter_sel_i == `SCS_FILTER_SINC);
    assign mod_tick   = conv_rise && (div == `SCS_MOD_DIV_LAST);
    assign period_end = mod_tick && (cnt == `SCS_CNT_W'(1));
    assign cmd_bits   = {shift[5:0], mosi_lvl};
    assign spi_start  = !cs_n_lvl && sclk_fall && (bit_cnt == `SCS_SPI_BIT7)
                        && (cmd_bits == `SCS_START_CMD7);
    assign start_evt  = start_rise || spi_start;

    always_comb
    begin
        next_state   = state;
        next_div     = conv_rise ? div + 4'h1 : div;
        next_cnt     = cnt;
        next_sup     = sup;
        next_shift   = shift;
        next_bit_cnt = bit_cnt;
        next_ready   = 1'b0;
        next_count   = count;

        // Command bytes are framed by chip select, shifted on SCLK falls
        if (cs_n_lvl)
        begin
            next_shift   = 7'h00;
            next_bit_cnt = 3'h0;
        end
        else if (sclk_fall)
        begin
            next_shift   = cmd_bits;
            next_bit_cnt = bit_cnt + 3'h1;
        end

        if (mod_tick && (cnt != `SCS_CNT_W'(1)))
        begin
            next_cnt = cnt - `SCS_CNT_W'(1);
        end

        // One sequence for both filters; only the suppression differs
        case (state)
            ST_IDLE:
            begin
                next_cnt = cnt;
            end
            ST_DELAY:
            begin
                if (period_end)
                begin
                    next_state = ST_SAMPLE;
                    next_cnt   = period;
                end
            end
            ST_SAMPLE:
            begin
                if (period_end)
                begin
                    if (filt_sinc && (sup != `SCS_SUP_OUTPUTS))
                    begin
                        next_sup = sup + 2'h1;
                        next_cnt = period;
                    end
                    else
                    begin
                        next_state = ST_OVERHEAD;
                        next_cnt   = overhead;
                    end
                end
            end
            ST_OVERHEAD:
            begin
                if (period_end)
                begin
                    next_ready = 1'b1;
                    next_count = count + 16'h0001;
                    next_cnt   = period;
                    next_state = continuous_i ? ST_NEXT : ST_IDLE;
                end
            end
            ST_NEXT:
            begin
                if (period_end)
                begin
                    next_ready = 1'b1;
                    next_count = count + 16'h0001;
                    next_cnt   = period;
                    next_state = continuous_i ? ST_NEXT : ST_IDLE;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase

        // A start restarts the sequence and aligns the modulator divider
        if (start_evt)
        begin
            next_state = ST_DELAY;
            next_cnt   = delay;
            next_sup   = 2'h0;
            next_div   = 4'h0;
            // A result completing under a restart is discarded with the sequence
            next_ready = 1'b0;
            next_count = count;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state   <= ST_IDLE;
            div     <= 4'h0;
            cnt     <= `SCS_CNT_W'(0);
            sup     <= 2'h0;
            shift   <= 7'h00;
            bit_cnt <= 3'h0;
            ready   <= 1'b0;
            count   <= 16'h0000;
        end
        else
        begin
            state   <= next_state;
            div     <= next_div;
            cnt     <= next_cnt;
            sup     <= next_sup;
            shift   <= next_shift;
            bit_cnt <= next_bit_cnt;
            ready   <= next_ready;
            count   <= next_count;
        end
    end

    assign busy_o         = (state != ST_IDLE);
    assign result_ready_o = ready;
    assign result_count_o = count;
    assign phase_o        = state;

    // Helper: converter clock rises seen since the last modulator tick or start
    logic [4:0] chk_rises;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || start_evt || mod_tick)
        begin
            chk_rises <= 5'h00;
        end
        else if (conv_rise)
        begin
            chk_rises <= chk_rises + 5'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_sample_end;
        (state == ST_SAMPLE) && period_end && !start_evt;
    endsequence

    sequence seq_oh_end;
        (state == ST_OVERHEAD) && period_end && !start_evt;
    endsequence

    a_start_to_delay: assert property (start_evt
        |=> (state == ST_DELAY) && (cnt == delay))
        else $error("start did not enter delay with selected count");

    a_spi_start_cmd: assert property (spi_start
        |=> (state == ST_DELAY) && (div == 4'h0) && !result_ready_o)
        else $error("command start did not restart the sequence");

    a_tick_sixteen: assert property (mod_tick && !$past(start_evt) |-> chk_rises == 5'h0F)
        else $error("modulator period not sixteen converter clocks");

    a_sinc_skip_oh: assert property (seq_sample_end ##0 (filt_sinc && sup < 2'h2)
        |=> (state == ST_SAMPLE) && (cnt == period))
        else $error("suppressed output entered overhead");

    a_settled_oh: assert property (seq_sample_end ##0 (!filt_sinc || sup == 2'h2)
        |=> (state == ST_OVERHEAD) && (cnt == overhead))
        else $error("settled output skipped overhead");

    a_ready_source: assert property (result_ready_o
        |-> $past(state) == ST_OVERHEAD || $past(state) == ST_NEXT)
        else $error("result flagged outside overhead or later period");

    a_sinc_suppress: assert property (result_ready_o && filt_sinc
        && $past(state) == ST_OVERHEAD |-> sup == 2'h2)
        else $error("sinc result before two suppressed outputs");

    a_cont_no_delay: assert property (seq_oh_end ##0 continuous_i
        |=> (state == ST_NEXT) && result_ready_o ##1 !result_ready_o)
        else $error("continuous mode did not proceed without delay");

    a_single_stop: assert property (seq_oh_end ##0 !continuous_i
        |=> (state == ST_IDLE) && result_ready_o && !busy_o)
        else $error("single shot did not stop after first result");

    a_count_step: assert property (result_ready_o
        |-> result_count_o == $past(result_count_o) + 16'h0001)
        else $error("result count did not advance with result");

endmodule : scs_sequencer

/* File: scs_sync3.sv */
`timescale 1ns/1ps
`include "scs_defs.svh"

module scs_sync3
    import scs_pkg::*;
#(
    parameter logic INIT = 1'b0
)
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
    logic fall;
    logic next_lvl;
    logic next_rise;
    logic next_fall;

    // A change is taken once the second and third stages agree
    always_comb
    begin
        next_lvl  = (s2 == s3) ? s3 : lvl;
        next_rise = next_lvl & ~lvl;
        next_fall = ~next_lvl & lvl;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s1   <= INIT;
            s2   <= INIT;
            s3   <= INIT;
            lvl  <= INIT;
            rise <= 1'b0;
            fall <= 1'b0;
        end
        else
        begin
            s1   <= async_i;
            s2   <= s1;
            s3   <= s2;
            lvl  <= next_lvl;
            rise <= next_rise;
            fall <= next_fall;
        end
    end

    assign level_o = lvl;
    assign rise_o  = rise;
    assign fall_o  = fall;

endmodule : scs_sync3

/* File: sinc3_conversion_sequencer_tb.sv */
`timescale 1ns/1ps

module sinc3_conversion_sequencer_tb;
    import scs_pkg::*;

    localparam int TICK = 16 * 6;

    logic        clk_i      = 1'b0;
    logic        rst_i      = 1'b1;
    logic        filter_sel = 1'b0;
    logic        continuous = 1'b0;
    logic [2:0]  delay_sel  = 3'h0;
    logic [3:0]  rate_sel   = 4'hD;
    logic        conv_clk;
    logic        start_pin;
    logic        sclk;
    logic        cs_n;
    logic        mosi;
    logic        busy_o;
    logic        result_ready_o;
    logic [15:0] result_count_o;
    logic [2:0]  phase_o;
    logic [2:0]  last_ph    = 3'h0;
    logic [15:0] exp_count  = 16'h0000;
    int          fails      = 0;
    int          num_checks = 0;
    int          n_res      = 0;
    int          seg        = 0;
    int          rate       = 13;
    int          exp_ph[$];
    int          exp_len[$];

    always #2.5 clk_i = ~clk_i;

    scs_host_model host
    (
        .clk_i       (clk_i),
        .conv_clk_o  (conv_clk),
        .start_pin_o (start_pin),
        .sclk_o      (sclk),
        .cs_n_o      (cs_n),
        .mosi_o      (mosi)
    );

    scs_sequencer DUT
    (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .conv_clk_i     (conv_clk),
        .start_pin_i    (start_pin),
        .sclk_i         (sclk),
        .cs_n_i         (cs_n),
        .mosi_i         (mosi),
        .filter_sel_i   (filter_sel),
        .continuous_i   (continuous),
        .delay_sel_i    (delay_sel),
        .rate_sel_i     (rate_sel),
        .busy_o         (busy_o),
        .result_ready_o (result_ready_o),
        .result_count_o (result_count_o),
        .phase_o        (phase_o)
    );

    task report_and_stop();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    task chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_val

    // Phase segment against the model; a negative length means any length
    task chk_len(input logic [2:0] ph, input int got);
        int e_ph;
        int e_len;
        e_ph  = (exp_ph.size() > 0) ? exp_ph.pop_front() : -1;
        e_len = (exp_len.size() > 0) ? exp_len.pop_front() : 0;
        num_checks++;
        if (ph !== 3'(e_ph) || (e_len >= 0 && (got < e_len - 8 || got > e_len + 8)))
        begin
            fails++;
            $display("BAD %0t phase %0d lasted %0d exp phase %0d for %0d", $time, ph, got,
                     e_ph, e_len);
        end
    endtask : chk_len

    task push_seg(input int ph, input int len);
        exp_ph.push_back(ph);
        exp_len.push_back(len);
    endtask : push_seg

    task push_seq(input logic ll, input int d, input int p, input int o, input int extra);
        push_seg(1, d * TICK);
        push_seg(2, (ll ? 1 : 3) * p * TICK);
        push_seg(3, o * TICK);
        repeat (extra) push_seg(4, p * TICK);
    endtask : push_seq

    // Negative target waits for idle with the model drained
    task wait_for(input int target);
        int i;
        for (i = 0; i < 40000; i++)
        begin
            @(posedge clk_i);
            if (target >= 0 && n_res >= target)
                return;
            if (target < 0 && phase_o === 3'h0 && busy_o === 1'b0 && exp_ph.size() == 0)
                return;
        end
        fails++;
        $display("BAD %0t wait ran out", $time);
        report_and_stop();
    endtask : wait_for

    always @(posedge clk_i)
    begin
        if (!rst_i)
        begin
            if (phase_o !== last_ph)
            begin
                if (last_ph !== 3'h0)
                    chk_len(last_ph, seg);
                seg     = 1;
                last_ph = phase_o;
            end
            else
                seg++;
            if (result_ready_o === 1'b1)
            begin
                n_res++;
                exp_count = exp_count + 16'h0001;
                chk_val(result_count_o, exp_count, "count");
            end
        end
    end

    initial
    begin
        void'($urandom(14016));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Sinc, single shot, default delay, started by the pin
        push_seq(1'b0, 14, 64, 40, 0);
        host.pulse_start();
        chk_val({15'h0000, busy_o}, 16'h0001, "busy");
        wait_for(-1);
        chk_val(16'(n_res), 16'h0001, "sinc results");
        // Sinc, continuous, started by command after a wrong byte
        n_res = 0;
        continuous <= 1'b1;
        delay_sel  <= 3'h7;
        @(posedge clk_i);
        host.send_byte(8'h0A);
        repeat (200) @(posedge clk_i);
        chk_val({13'h0000, phase_o}, 16'h0000, "wrong byte started");
        push_seq(1'b0, 1, 64, 40, 1);
        host.send_byte(8'h09);
        wait_for(1);
        continuous <= 1'b0;
        wait_for(-1);
        chk_val(16'(n_res), 16'h0002, "continuous results");
        // Low-latency, restart while sampling, random rate
        n_res = 0;
        filter_sel <= 1'b1;
        rate  = $urandom_range(13, 12);
        rate_sel <= rate[3:0];
        repeat (2) @(posedge clk_i);
        push_seg(1, TICK);
        push_seg(2, -1);
        push_seq(1'b1, 1, (rate == 12) ? 128 : 64, 40, 0);
        host.pulse_start();
        repeat (300) @(posedge clk_i);
        host.pulse_start();
        wait_for(-1);
        chk_val(16'(n_res), 16'h0001, "restart results");
        chk_val(result_count_o, 16'h0004, "total");
        chk_val({12'h000, busy_o, phase_o}, 16'h0000, "idle");
        report_and_stop();
    end
endmodule : sinc3_conversion_sequencer_tb
